/* File: hdl/rbl_lane.sv */
// Receive bit lane: serial capture, deserializer and configuration port.
`timescale 1ns/100ps
module rbl_lane (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] lane_index,
  input wire logic serial_in,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic word_valid,
  input wire logic word_ready,
  output logic [7:0] word_data,
  output logic [3:0] word_width,
  input wire rbl_pkg::rbl_ctrl_bus_t ctrl_in,
  output rbl_pkg::rbl_ctrl_bus_t ctrl_out,
  output logic [2:0] div_mode_hint,
  output logic overflow
);
  logic [31:0] ctrl;
  logic [7:0] shift;
  logic [3:0] bit_count;
  logic sticky_overflow;
  logic sticky_bad_cfg;
  logic [31:0] word_total;
  rbl_pkg::rbl_ctrl_bus_t ctrl_rx_q;
  rbl_pkg::rbl_word_t buf_out;
  rbl_pkg::rbl_word_t buf_in_word;
  logic buf_in_ready;

  function automatic logic [3:0] width_of(input logic wide);
    width_of = wide ? rbl_pkg::WIDTH_8 : rbl_pkg::WIDTH_4;
  endfunction : width_of

  wire [1:0] kind_raw = ctrl[rbl_pkg::CTRL_KIND_LSB +: 2];
  wire lane_enable = ctrl[rbl_pkg::CTRL_EN_BIT];
  wire [3:0] cur_width = width_of(ctrl[rbl_pkg::CTRL_WIDE_BIT]);
  // Strobe mode off lane zero is flagged and treated as plain data.
  wire strobe_misplaced = (kind_raw == rbl_pkg::RBL_KIND_STROBE) &&
                          (lane_index != rbl_pkg::LANE_ZERO);
  wire kind_illegal = (kind_raw == 2'h3);
  // All kinds sample the pin as a data bit; strobe included.
  wire sample_bit = serial_in;
  wire word_done = lane_enable && (bit_count == cur_width - 4'h1);
  wire [7:0] next_shift = {shift[6:0], sample_bit};
  wire [7:0] word_bits = (cur_width == rbl_pkg::WIDTH_4) ?
                         {4'h0, next_shift[3:0]} : next_shift;
  wire next_overflow = word_done && !buf_in_ready;

  assign buf_in_word = '{data: word_bits, width: cur_width};

  // Division hint lets the controller side match the width.
  assign div_mode_hint = (cur_width == rbl_pkg::WIDTH_4) ?
                         rbl_pkg::DIV_FOR_4 : rbl_pkg::DIV_FOR_8;
  assign word_data = buf_out.data;
  assign word_width = buf_out.width;
  assign overflow = sticky_overflow;
  // Control buses are dedicated; the lane echoes a registered copy back.
  assign ctrl_out = ctrl_rx_q;

  wire sel_ctrl = (reg_addr == rbl_pkg::ADDR_CTRL);
  wire sel_status = (reg_addr == rbl_pkg::ADDR_STATUS);
  wire sel_ctrl_rx = (reg_addr == rbl_pkg::ADDR_CTRL_RX);
  wire [31:0] status_word = {word_total[23:0], 4'h0, buf_in_ready,
                             sticky_bad_cfg, sticky_overflow, lane_enable};
  wire [31:0] next_rdata = sel_ctrl ? ctrl :
                           sel_status ? status_word :
                           sel_ctrl_rx ? ctrl_in.rx[31:0] : 32'h0;

  rbl_buffer u_buffer (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(word_done),
    .in_ready(buf_in_ready),
    .in_word(buf_in_word),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_word(buf_out)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= rbl_pkg::CTRL_RESET;
      shift <= 8'h0;
      bit_count <= 4'h0;
      sticky_overflow <= 1'b0;
      sticky_bad_cfg <= 1'b0;
      word_total <= 32'h0;
      reg_rdata <= 32'h0;
      ctrl_rx_q <= '0;
    end else begin
      ctrl_rx_q <= ctrl_in;
      reg_rdata <= reg_read ? next_rdata : 32'h0;
      if (reg_write && sel_ctrl) begin
        ctrl <= {28'h0, reg_wdata[3:0]};
      end
      if (reg_write && sel_ctrl) begin
        bit_count <= 4'h0;
      end else if (word_done) begin
        bit_count <= 4'h0;
      end else if (lane_enable) begin
        bit_count <= bit_count + 4'h1;
      end
      if (lane_enable) begin
        shift <= next_shift;
      end
      if (word_done && buf_in_ready) begin
        word_total <= word_total + 32'h1;
      end
      // Set wins over a same-cycle clear by writing the status word.
      if (next_overflow) begin
        sticky_overflow <= 1'b1;
      end else if (reg_write && sel_status && reg_wdata[1]) begin
        sticky_overflow <= 1'b0;
      end
      if (strobe_misplaced || kind_illegal) begin
        sticky_bad_cfg <= 1'b1;
      end else if (reg_write && sel_status && reg_wdata[2]) begin
        sticky_bad_cfg <= 1'b0;
      end
    end
  end
endmodule : rbl_lane

/* File: pkg/rbl_pkg.sv */
// Package for the receive bit lane deserializer: modes, widths and carriers.
// Behaviour
// - Strobe-as-sample mode samples the strobe input as ordinary data bits.
// - Plain data capture is allowed on every lane, lane zero included.
// - Parallel word width is 4 or 8 bits, default 8.
// - Lane has 40-bit control buses in and out for receive and transmit.
package rbl_pkg;
  localparam int unsigned CTRL_W = 40;
  localparam int unsigned WORD_W = 8;
  localparam logic [3:0] WIDTH_4 = 4'h4;
  localparam logic [3:0] WIDTH_8 = 4'h8;
  localparam logic [3:0] WIDTH_RESET = 4'h8;
  localparam logic [2:0] DIV_FOR_4 = 3'h2;
  localparam logic [2:0] DIV_FOR_8 = 3'h4;
  localparam logic [1:0] LANE_ZERO = 2'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CTRL_RX = 4'h2;
  localparam int unsigned CTRL_KIND_LSB = 0;
  localparam int unsigned CTRL_WIDE_BIT = 2;
  localparam int unsigned CTRL_EN_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;

  typedef enum logic [1:0] {
    RBL_KIND_DATA = 2'h0,
    RBL_KIND_STROBE = 2'h1,
    RBL_KIND_UNRELATED = 2'h2
  } rbl_kind_t;

  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic [3:0] width;
  } rbl_word_t;

  typedef struct packed {
    logic [CTRL_W-1:0] rx;
    logic [CTRL_W-1:0] tx;
  } rbl_ctrl_bus_t;
endpackage : rbl_pkg

/* File: hdl/rbl_buffer.sv */
// Two-entry valid/ready buffer for parallel words.
`timescale 1ns/100ps
module rbl_buffer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire rbl_pkg::rbl_word_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output rbl_pkg::rbl_word_t out_word
);
  rbl_pkg::rbl_word_t store [2];
  logic [1:0] count;
  logic rd_ptr;
  logic wr_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_word = store[rd_ptr];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      store[0] <= '0;
      store[1] <= '0;
    end else begin
      if (push) begin
        store[wr_ptr] <= in_word;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : rbl_buffer

/* File: test/rbl_lane_asserts.sv */
// Port checker for the receive bit lane.
`timescale 1ns/100ps
module rbl_lane_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire logic [7:0] word_data,
  input wire logic [3:0] word_width,
  input wire rbl_pkg::rbl_ctrl_bus_t ctrl_in,
  input wire rbl_pkg::rbl_ctrl_bus_t ctrl_out,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [31:0] reg_rdata,
  input wire logic overflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence held_word;
    word_valid && !word_ready;
  endsequence
  sequence kept_word;
    word_valid && $stable(word_data) && $stable(word_width);
  endsequence
  a_ctrl_delay: assert property (
    $past(reset_n) |-> ctrl_out == $past(ctrl_in)) else $error("ctrl lag");
  a_word_held: assert property (
    held_word |=> kept_word) else $error("stalled word lost");
  a_width_legal: assert property (
    word_valid |-> word_width inside {4'h4, 4'h8}) else $error("bad width");
  a_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 32'h0) else $error("rdata not idle");
  a_overflow_kept: assert property (
    overflow && !reg_write |=> overflow) else $error("overflow lost");
endmodule : rbl_lane_asserts
bind rbl_lane rbl_lane_asserts u_chk (.clk, .reset_n, .word_valid,
  .word_ready, .word_data, .word_width, .ctrl_in, .ctrl_out, .reg_read,
  .reg_write, .reg_rdata, .overflow);

/* File: test/rbl_partner.sv */
// Far side model: controller buses and a word consumer.
`timescale 1ns/100ps
module rbl_partner (
  input wire logic clk,
  input wire rbl_pkg::rbl_ctrl_bus_t from_lane,
  output rbl_pkg::rbl_ctrl_bus_t to_lane = '0,
  output logic ready = 1'h1
);
  // The consumer stalls at random, one cycle in four on average, so the buffer must hold words.
  always @(posedge clk) begin
    to_lane <= rbl_pkg::rbl_ctrl_bus_t'(80'({$urandom, $urandom, $urandom}));
    ready <= ($urandom % 4) != 0;
  end
endmodule : rbl_partner

/* File: test/rbl_lane_test.sv */
// Self-checking bench for the receive bit lane.
`timescale 1ns/100ps
module rbl_lane_test;
  logic clk = 1'h0, reset_n = 1'h0, serial_in = 1'h0, rp = 1'h0;
  logic reg_write = 1'h0, reg_read = 1'h0, word_valid, word_ready;
  logic [1:0] lane_index = 2'h0;
  logic [3:0] reg_addr = 4'h0, word_width;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0] word_data;
  logic [2:0] div_mode_hint;
  logic overflow;
  rbl_pkg::rbl_ctrl_bus_t ctrl_in, ctrl_out;
  rbl_pkg::rbl_word_t wq[$];
  logic [31:0] rq[$];
  int err_total = 0, n_tests = 0, cyc = 0;
  rbl_lane DUT (.clk, .reset_n, .lane_index, .serial_in, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .word_valid, .word_ready,
    .word_data, .word_width, .ctrl_in, .ctrl_out, .div_mode_hint,
    .overflow);
  rbl_partner far (.clk, .from_lane(ctrl_out), .to_lane(ctrl_in),
    .ready(word_ready));
  initial forever #5 clk = ~clk;
  task automatic report_and_stop;
    $display("compared %0d bad %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_read <= 1'h1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge clk);
    reg_read <= 1'h0;
  endtask : rd
  // The disabling write lands on the edge that takes the final bit.
  task automatic run(input logic [1:0] k, input logic wide);
    int w;
    logic [7:0] acc;
    logic b;
    logic [2:0] hint_exp;
    w = wide ? 8 : 4;
    hint_exp = wide ? rbl_pkg::DIV_FOR_8 : rbl_pkg::DIV_FOR_4;
    acc = 8'h0;
    for (int i = 0; i <= 3 * w; i++) begin
      @(posedge clk);
      b = 1'($urandom);
      reg_write <= (i == 0 || i == 3 * w);
      reg_addr <= rbl_pkg::ADDR_CTRL;
      reg_wdata <= (i == 0) ? {28'h0, 1'h1, wide, k} : 32'h4;
      serial_in <= b;
      acc = {acc[6:0], b};
      // The bit beside the enable write is not taken; words start at i=1.
      if (i > 0 && i % w == 0) wq.push_back({acc, 4'(w)});
      if (i == 2) begin
        n_tests++;
        if (div_mode_hint !== hint_exp) begin
          err_total++;
          $display("BAD hint exp %0d got %0d", hint_exp, div_mode_hint);
        end
      end
    end
    @(posedge clk);
    reg_write <= 1'h0;
    repeat (12) @(posedge clk);
    $display("kind %0d width %0d done", k, w);
  endtask : run
  always @(posedge clk) begin
    rbl_pkg::rbl_word_t x;
    logic bad;
    cyc++;
    if (cyc > 2000) begin
      err_total++;
      report_and_stop();
    end
    if (rp) begin
      n_tests++;
      if (reg_rdata !== rq[0]) begin
        err_total++;
        $display("BAD rdata exp %h got %h", rq[0], reg_rdata);
      end
      void'(rq.pop_front());
    end
    rp = reg_read;
    if (word_valid === 1'h1 && word_ready === 1'h1) begin
      x = wq.pop_front();
      n_tests++;
      bad = word_width !== x.width;
      bad |= ((word_data ^ x.data) & (x.width[3] ? 8'hff : 8'h0f)) !== 8'h0;
      if (bad) begin
        err_total++;
        $display("BAD word exp %h got %h", x, {word_data, word_width});
      end
    end
  end
  initial begin
    void'($urandom(54));
    repeat (4) @(posedge clk);
    reset_n <= 1'h1;
    rd(rbl_pkg::ADDR_CTRL, rbl_pkg::CTRL_RESET);
    rd(4'hf, 32'h0);
    for (int k = 0; k < 3; k++) begin
      lane_index <= (k == 1) ? 2'h0 : 2'($urandom);
      for (int j = 0; j < 2; j++) run(2'(k), 1'(j));
    end
    rd(rbl_pkg::ADDR_STATUS, 32'h0000_1208);
    @(posedge clk);
    reg_write <= 1'h1;
    reg_addr <= rbl_pkg::ADDR_CTRL;
    reg_wdata <= 32'h0000_0001;
    lane_index <= 2'h1;
    @(posedge clk);
    reg_write <= 1'h0;
    rd(rbl_pkg::ADDR_STATUS, 32'h0000_120c);
    repeat (2) @(posedge clk);
    n_tests++;
    if (wq.size() != 0 || overflow !== 1'h0) begin
      err_total++;
      $display("BAD words_left exp 0 got %0d overflow %b", wq.size(), overflow);
    end
    report_and_stop();
  end
endmodule : rbl_lane_test
